// *** verilog/mgmc_regs.sv ***
/*
 * mgmc_regs: serial-port register bank for apparent-power gains, the operating mode,
 * the read-back ones count and the die revision.
 * Assumes a host on a four-wire serial port: chip select active low, clock idling high,
 * data in sampled on the falling clock edge, data out changed on the rising edge, MSB first.
 * The serial clock must stay below one eighth of clk_in since all pins are oversampled.
 */
// Contract
// RULE1: phase A apparent gain is a writable 12-bit register resetting to zero.
// RULE2: phase B and phase C gains are writable 12-bit registers at 39h and 3Ah, reset zero.
// RULE3: a read-only 8-bit register holds the number of ones in the last value read out.
// RULE4: a read-only 8-bit die revision register sits at 3Fh and cannot be changed.
// RULE5: the operating mode register sits at 0Ah and host writes set the configuration.
// RULE6: mode bit 0 bypasses the current high-pass filters, bit 1 the low-pass, both reset 0.
// RULE7: mode bit 2 holds the frequency pulse output inactive and resets to one.
// RULE8: mode bits 3 to 5 form a shutdown field resetting to zero, zero meaning normal.
// RULE9: the field top bit alone keeps conversion but swaps current and voltage inputs.
// RULE10: other codes turn off current or voltage converters, sleep or power down.
// RULE11: after a software reset the host waits at least 18 us before the next transfer.
// RULE12: writes to read-only and reserved addresses 3Bh to 3Dh change nothing.
`timescale 1ns/100ps
module mgmc_regs
   import mgmc_pkg::*;
#(
   // arbitrary neutral value
   parameter logic [7:0] DIE_REVISION = 8'h5A
)(
   // clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // serial port pins
   input wire logic spi_csn_in,
   input wire logic spi_sclk_in,
   input wire logic spi_din_in,
   output logic spi_dout_out,
   output logic spi_dout_oe_out,
   // frequency pulse path, same clock domain
   input wire logic freq_pulse_raw_in,
   output logic freq_pulse_output_out,
   // gains
   output logic [11:0] phase_a_apparent_gain_out,
   output logic [11:0] phase_b_apparent_gain_out,
   output logic [11:0] phase_c_apparent_gain_out,
   // mode controls
   output logic highpass_bypass_out,
   output logic lowpass_bypass_out,
   output logic freq_pulse_off_out,
   output logic current_adc_off_out,
   output logic voltage_adc_off_out,
   output logic channel_swap_out,
   output logic sleep_out,
   output logic power_down_out,
   output logic soft_reset_out
);

   // ==========================================================
   // helpers
   function automatic logic [7:0] ones_of(input logic [15:0] value);
      logic [7:0] total;
      total = 8'h00;
      for (int i = 0; i < 16; i++) begin
         total = total + {7'h00, value[i]};
      end
      return total;
   endfunction

   function automatic logic [4:0] length_of(input logic [5:0] addr);
      logic [4:0] len;
      len = MGMC_LEN_BYTE;
      if (addr == MGMC_ADDR_PHASE_A_GAIN || addr == MGMC_ADDR_PHASE_B_GAIN ||
          addr == MGMC_ADDR_PHASE_C_GAIN) begin
         len = MGMC_LEN_WORD;
      end
      return len;
   endfunction

   // ==========================================================
   // pin synchronisers
   logic csn_meta_reg, csn_sync_reg;
   logic sclk_meta_reg, sclk_sync_reg, sclk_prev_reg;
   logic din_meta_reg, din_sync_reg;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         csn_meta_reg <= 1'b1;
         csn_sync_reg <= 1'b1;
         sclk_meta_reg <= 1'b1;
         sclk_sync_reg <= 1'b1;
         sclk_prev_reg <= 1'b1;
         din_meta_reg <= 1'b0;
         din_sync_reg <= 1'b0;
      end else begin
         csn_meta_reg <= spi_csn_in;
         csn_sync_reg <= csn_meta_reg;
         sclk_meta_reg <= spi_sclk_in;
         sclk_sync_reg <= sclk_meta_reg;
         sclk_prev_reg <= sclk_sync_reg;
         din_meta_reg <= spi_din_in;
         din_sync_reg <= din_meta_reg;
      end
   end

   wire sclk_fall = sclk_prev_reg & ~sclk_sync_reg;
   wire sclk_rise = ~sclk_prev_reg & sclk_sync_reg;
   wire selected = ~csn_sync_reg;

   // ==========================================================
   // register storage
   logic [11:0] gain_a_reg, gain_b_reg, gain_c_reg;
   logic [7:0] mode_reg;
   logic [7:0] ones_reg, ones_next;

   // ==========================================================
   // frame state
   mgmc_state_type state_reg, state_next;
   logic [4:0] count_reg, count_next;
   logic [15:0] shift_reg, shift_next;
   logic [5:0] addr_reg, addr_next;
   logic [4:0] len_reg, len_next;
   logic [7:0] pend_ones_reg, pend_ones_next;
   logic dout_reg, dout_next;

   wire [7:0] cmd_byte = {shift_reg[6:0], din_sync_reg};
   wire [5:0] cmd_addr = cmd_byte[5:0];
   wire cmd_is_write = cmd_byte[MGMC_CMD_WRITE_BIT];
   wire [4:0] cmd_len = length_of(cmd_addr);
   wire [15:0] wr_word = {shift_reg[14:0], din_sync_reg};
   wire last_bit = (count_reg == len_reg - 5'h01);

   // read value, left aligned in 16 bits so the MSB always leaves from bit 15
   wire [15:0] rd_value =
      (cmd_addr == MGMC_ADDR_PHASE_A_GAIN) ? {4'h0, gain_a_reg} :
      (cmd_addr == MGMC_ADDR_PHASE_B_GAIN) ? {4'h0, gain_b_reg} :
      (cmd_addr == MGMC_ADDR_PHASE_C_GAIN) ? {4'h0, gain_c_reg} :
      (cmd_addr == MGMC_ADDR_OPERATING_MODE) ? {mode_reg, 8'h00} :
      (cmd_addr == MGMC_ADDR_ONES_COUNT) ? {ones_reg, 8'h00} :
      (cmd_addr == MGMC_ADDR_DIE_REVISION) ? {DIE_REVISION, 8'h00} : // RULE4
      16'h0000;

   // write strobe: only the four writable addresses have storage behind them
   wire write_done = (state_reg == MGMC_ST_WDATA) && sclk_fall && last_bit && selected; // RULE12
   wire wr_mode = write_done && (addr_reg == MGMC_ADDR_OPERATING_MODE); // RULE5
   wire wr_gain_a = write_done && (addr_reg == MGMC_ADDR_PHASE_A_GAIN); // RULE1
   wire wr_gain_b = write_done && (addr_reg == MGMC_ADDR_PHASE_B_GAIN); // RULE2
   wire wr_gain_c = write_done && (addr_reg == MGMC_ADDR_PHASE_C_GAIN); // RULE2
   // writes to 3Bh-3Dh, 3Eh, 3Fh and any other address fall through here
   wire soft_reset = wr_mode && wr_word[MGMC_MODE_SOFT_RESET_BIT_BIT]; // RULE5
   wire read_done = (state_reg == MGMC_ST_RDATA) && sclk_fall && last_bit && selected;

   // ==========================================================
   // frame sequencer
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      shift_next = shift_reg;
      addr_next = addr_reg;
      len_next = len_reg;
      pend_ones_next = pend_ones_reg;
      dout_next = dout_reg;
      ones_next = ones_reg;
      if (!selected) begin
         state_next = MGMC_ST_IDLE;
      end else begin
         unique case (state_reg)
            MGMC_ST_IDLE: begin
               state_next = MGMC_ST_CMD;
               count_next = 5'h00;
               shift_next = 16'h0000;
               len_next = MGMC_CMD_LEN;
            end
            MGMC_ST_CMD: begin
               if (sclk_fall) begin
                  shift_next = wr_word;
                  count_next = count_reg + 5'h01;
                  if (last_bit) begin
                     addr_next = cmd_addr;
                     len_next = cmd_len;
                     count_next = 5'h00;
                     if (cmd_is_write) begin
                        state_next = MGMC_ST_WDATA;
                     end else begin
                        shift_next = (cmd_len == MGMC_LEN_WORD) ? rd_value : rd_value;
                        pend_ones_next = ones_of(rd_value); // RULE3
                        state_next = MGMC_ST_RDATA;
                     end
                  end
               end
            end
            MGMC_ST_WDATA: begin
               if (sclk_fall) begin
                  shift_next = wr_word;
                  count_next = count_reg + 5'h01;
                  if (last_bit) begin
                     state_next = MGMC_ST_DONE;
                  end
               end
            end
            MGMC_ST_RDATA: begin
               if (sclk_rise) begin
                  dout_next = shift_reg[15];
                  shift_next = {shift_reg[14:0], 1'b0};
               end
               if (sclk_fall) begin
                  count_next = count_reg + 5'h01;
                  if (last_bit) begin
                     ones_next = pend_ones_reg; // RULE3
                     state_next = MGMC_ST_DONE;
                  end
               end
            end
            MGMC_ST_DONE: begin
               state_next = MGMC_ST_DONE;
            end
            default: begin
               state_next = MGMC_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_reg <= MGMC_ST_IDLE;
         count_reg <= 5'h00;
         shift_reg <= 16'h0000;
         addr_reg <= 6'h00;
         len_reg <= MGMC_CMD_LEN;
         pend_ones_reg <= MGMC_ONES_RESET;
         dout_reg <= 1'b0;
         ones_reg <= MGMC_ONES_RESET;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         shift_reg <= shift_next;
         addr_reg <= addr_next;
         len_reg <= len_next;
         pend_ones_reg <= pend_ones_next;
         dout_reg <= dout_next;
         ones_reg <= ones_next;
      end
   end

   // ==========================================================
   // writable registers; software reset restores every default
   // and the host must then leave the port idle for 18 us
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         gain_a_reg <= MGMC_GAIN_RESET; // RULE1
         gain_b_reg <= MGMC_GAIN_RESET; // RULE2
         gain_c_reg <= MGMC_GAIN_RESET; // RULE2
         mode_reg <= MGMC_MODE_RESET; // RULE6 RULE7 RULE8
      end else if (soft_reset) begin
         gain_a_reg <= MGMC_GAIN_RESET;
         gain_b_reg <= MGMC_GAIN_RESET;
         gain_c_reg <= MGMC_GAIN_RESET;
         mode_reg <= MGMC_MODE_RESET; // RULE11
      end else begin
         if (wr_gain_a) begin
            gain_a_reg <= wr_word[11:0]; // RULE1
         end
         if (wr_gain_b) begin
            gain_b_reg <= wr_word[11:0]; // RULE2
         end
         if (wr_gain_c) begin
            gain_c_reg <= wr_word[11:0]; // RULE2
         end
         if (wr_mode) begin
            mode_reg <= wr_word[7:0]; // RULE5
         end
      end
   end

   // ==========================================================
   // mode decode and registered outputs
   logic dec_cur_off, dec_volt_off, dec_swap, dec_sleep, dec_pd;

   mgmc_mode_decode u_decode (
      .shutdown_field_in (mode_reg[MGMC_MODE_SHDN_MSB:MGMC_MODE_SHDN_LSB]), // RULE8
      .current_adc_off_out (dec_cur_off),
      .voltage_adc_off_out (dec_volt_off),
      .channel_swap_out (dec_swap),
      .sleep_out (dec_sleep),
      .power_down_out (dec_pd)
   );

   wire dout_oe_next = selected && (state_reg == MGMC_ST_RDATA);
   wire pulse_next = freq_pulse_raw_in & ~mode_reg[MGMC_MODE_FPO_BIT];

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         spi_dout_out <= 1'b0;
         spi_dout_oe_out <= 1'b0;
         freq_pulse_output_out <= 1'b0;
         phase_a_apparent_gain_out <= MGMC_GAIN_RESET;
         phase_b_apparent_gain_out <= MGMC_GAIN_RESET;
         phase_c_apparent_gain_out <= MGMC_GAIN_RESET;
         highpass_bypass_out <= 1'b0;
         lowpass_bypass_out <= 1'b0;
         freq_pulse_off_out <= 1'b1;
         current_adc_off_out <= 1'b0;
         voltage_adc_off_out <= 1'b0;
         channel_swap_out <= 1'b0;
         sleep_out <= 1'b0;
         power_down_out <= 1'b0;
         soft_reset_out <= 1'b0;
      end else begin
         spi_dout_out <= dout_reg;
         spi_dout_oe_out <= dout_oe_next;
         freq_pulse_output_out <= pulse_next; // RULE7
         phase_a_apparent_gain_out <= gain_a_reg;
         phase_b_apparent_gain_out <= gain_b_reg;
         phase_c_apparent_gain_out <= gain_c_reg;
         highpass_bypass_out <= mode_reg[MGMC_MODE_HPF_BIT]; // RULE6
         lowpass_bypass_out <= mode_reg[MGMC_MODE_LPF_BIT]; // RULE6
         freq_pulse_off_out <= mode_reg[MGMC_MODE_FPO_BIT]; // RULE7
         current_adc_off_out <= dec_cur_off; // RULE10
         voltage_adc_off_out <= dec_volt_off; // RULE10
         channel_swap_out <= dec_swap; // RULE9
         sleep_out <= dec_sleep; // RULE10
         power_down_out <= dec_pd; // RULE10
         soft_reset_out <= soft_reset;
      end
   end

endmodule

// *** verilog/mgmc_pkg.sv ***
/*
 * mgmc_pkg: shared constants for the meter gain, mode and checksum register block.
 * Assumes a 6-bit serial register address space and registers at most 16 bits on the wire.
 */
package mgmc_pkg;

   // ==========================================================
   // register addresses (word addresses on the serial port)
   localparam logic [5:0] MGMC_ADDR_OPERATING_MODE = 6'h0A;
   localparam logic [5:0] MGMC_ADDR_PHASE_A_GAIN = 6'h38;
   localparam logic [5:0] MGMC_ADDR_PHASE_B_GAIN = 6'h39;
   localparam logic [5:0] MGMC_ADDR_PHASE_C_GAIN = 6'h3A;
   localparam logic [5:0] MGMC_ADDR_RSVD_FIRST = 6'h3B;
   localparam logic [5:0] MGMC_ADDR_RSVD_LAST = 6'h3D;
   localparam logic [5:0] MGMC_ADDR_ONES_COUNT = 6'h3E;
   localparam logic [5:0] MGMC_ADDR_DIE_REVISION = 6'h3F;

   // ==========================================================
   // widths and reset values
   localparam int MGMC_GAIN_W = 12;
   localparam int MGMC_BYTE_W = 8;
   localparam logic [11:0] MGMC_GAIN_RESET = 12'h000;
   localparam logic [7:0] MGMC_MODE_RESET = 8'h04;
   localparam logic [7:0] MGMC_ONES_RESET = 8'h00;

   // ==========================================================
   // operating_mode field positions
   localparam int MGMC_MODE_HPF_BIT = 0;
   localparam int MGMC_MODE_LPF_BIT = 1;
   localparam int MGMC_MODE_FPO_BIT = 2;
   localparam int MGMC_MODE_SHDN_LSB = 3;
   localparam int MGMC_MODE_SHDN_MSB = 5;
   localparam int MGMC_MODE_SOFT_RESET_BIT_BIT = 6;
   localparam int MGMC_MODE_RSVD_BIT = 7;

   // ==========================================================
   // serial frame layout
   localparam int MGMC_CMD_WRITE_BIT = 7;
   localparam logic [4:0] MGMC_CMD_LEN = 5'h08;
   localparam logic [4:0] MGMC_LEN_BYTE = 5'h08;
   localparam logic [4:0] MGMC_LEN_WORD = 5'h10;

   typedef enum logic [2:0] {
      MGMC_ST_IDLE = 3'b000,
      MGMC_ST_CMD = 3'b001,
      MGMC_ST_WDATA = 3'b010,
      MGMC_ST_RDATA = 3'b011,
      MGMC_ST_DONE = 3'b100
   } mgmc_state_type;

endpackage

// *** verilog/mgmc_mode_decode.sv ***
/*
 * mgmc_mode_decode: turns the three-bit converter shutdown field into converter controls.
 * Purely combinational; the instantiating module registers every result.
 */
`timescale 1ns/100ps
module mgmc_mode_decode
   import mgmc_pkg::*;
(
   // shutdown field
   input wire logic [2:0] shutdown_field_in,
   // converter controls
   output logic current_adc_off_out,
   output logic voltage_adc_off_out,
   output logic channel_swap_out,
   output logic sleep_out,
   output logic power_down_out
);

   // ==========================================================
   // field decode
   wire low_bit = shutdown_field_in[0];
   wire mid_bit = shutdown_field_in[1];
   wire top_bit = shutdown_field_in[2];
   wire both_low = low_bit & mid_bit;

   assign current_adc_off_out = low_bit & ~mid_bit; // RULE10
   assign voltage_adc_off_out = mid_bit & ~low_bit; // RULE10
   // swap applies with normal conversion or one converter bank off, not in power-down
   assign channel_swap_out = top_bit & ~both_low; // RULE9
   assign sleep_out = both_low & ~top_bit; // RULE10
   assign power_down_out = both_low & top_bit; // RULE10

endmodule

// *** dv/mgmc_regs_sva.sv ***
/*
 * mgmc_regs_chk: concurrent checks on the ports of the gain, mode and checksum block.
 * Assumes the single clk_in domain; attached to every mgmc_regs by the bind at the foot.
 */
`timescale 1ns/100ps
module mgmc_regs_chk (
   // clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // serial port
   input wire logic spi_csn_in,
   input wire logic spi_dout_oe_out,
   // frequency pulse path
   input wire logic freq_pulse_raw_in,
   input wire logic freq_pulse_output_out,
   input wire logic freq_pulse_off_out,
   // gains and converter controls
   input wire logic [11:0] phase_a_apparent_gain_out,
   input wire logic [11:0] phase_b_apparent_gain_out,
   input wire logic [11:0] phase_c_apparent_gain_out,
   input wire logic current_adc_off_out,
   input wire logic voltage_adc_off_out,
   input wire logic channel_swap_out,
   input wire logic sleep_out,
   input wire logic power_down_out,
   input wire logic soft_reset_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // ==========================================================
   // frame idle sequences, long enough to cover the pin synchronisers
   sequence s_idle;
      spi_csn_in [*6];
   endsequence
   sequence s_idle_long;
      spi_csn_in [*8];
   endsequence
   // ==========================================================
   // assertions
   a_oe_idle_low: assert property (s_idle |-> !spi_dout_oe_out)
      else $error("dout enabled outside a frame");
   a_fpo_gate_open: assert property (!freq_pulse_off_out && $stable(freq_pulse_off_out)
      |-> freq_pulse_output_out == $past(freq_pulse_raw_in)) else $error("pulse not passed");
   a_fpo_held_off: assert property (freq_pulse_off_out && $past(freq_pulse_off_out)
      |-> !freq_pulse_output_out) else $error("pulse leaked while off");
   a_adc_off_excl: assert property (!(current_adc_off_out && voltage_adc_off_out))
      else $error("both converter groups off");
   a_sleep_decode: assert property (sleep_out |-> !(current_adc_off_out ||
      voltage_adc_off_out || channel_swap_out || power_down_out)) else $error("sleep decode");
   a_pd_decode: assert property (power_down_out |-> !(current_adc_off_out ||
      voltage_adc_off_out || channel_swap_out || sleep_out)) else $error("power-down decode");
   a_soft_pulse: assert property (soft_reset_out |=> !soft_reset_out)
      else $error("soft reset pulse too long");
   a_soft_defaults: assert property (soft_reset_out |-> ##[0:3] (phase_a_apparent_gain_out ==
      12'h000 && phase_b_apparent_gain_out == 12'h000 && phase_c_apparent_gain_out == 12'h000
      && freq_pulse_off_out && !sleep_out && !power_down_out)) else $error("defaults lost");
   a_gain_hold_idle: assert property (s_idle_long |-> $stable(phase_a_apparent_gain_out) &&
      $stable(phase_b_apparent_gain_out) && $stable(phase_c_apparent_gain_out))
      else $error("gain changed outside a frame");
endmodule

bind mgmc_regs mgmc_regs_chk u_chk (.clk_in(clk_in), .rstn_in(rstn_in), .spi_csn_in(spi_csn_in),
   .spi_dout_oe_out(spi_dout_oe_out), .freq_pulse_raw_in(freq_pulse_raw_in),
   .freq_pulse_output_out(freq_pulse_output_out), .freq_pulse_off_out(freq_pulse_off_out),
   .phase_a_apparent_gain_out(phase_a_apparent_gain_out),
   .phase_b_apparent_gain_out(phase_b_apparent_gain_out),
   .phase_c_apparent_gain_out(phase_c_apparent_gain_out),
   .current_adc_off_out(current_adc_off_out), .voltage_adc_off_out(voltage_adc_off_out),
   .channel_swap_out(channel_swap_out), .sleep_out(sleep_out),
   .power_down_out(power_down_out), .soft_reset_out(soft_reset_out));

// *** dv/mgmc_host_model.sv ***
/*
 * mgmc_host_model: serial host driving whole frames into the register block.
 * Assumes pins may change only on falling clk_in edges; sclk parks high between frames.
 */
`timescale 1ns/100ps
module mgmc_host_model (
   // clock
   input wire logic clk_in,
   // serial port pins
   output logic spi_csn_out,
   output logic spi_sclk_out,
   output logic spi_din_out,
   input wire logic spi_dout_in,
   input wire logic spi_dout_oe_in
);
   initial begin
      spi_csn_out = 1'b1;
      spi_sclk_out = 1'b1;
      spi_din_out = 1'b0;
   end
   // ==========================================================
   // one frame: 8 clk low and 8 clk high phases, twice the minimum
   task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int nb,
                       output logic [15:0] rd);
      logic [23:0] sh;
      sh = (nb == 16) ? {cmd, wd} : {cmd, wd[7:0], 8'h00};
      rd = 16'h0000;
      @(negedge clk_in);
      spi_csn_out <= 1'b0;
      repeat (4) @(negedge clk_in);
      for (int i = 0; i < 8 + nb; i++) begin
         spi_din_out <= sh[23 - i];
         repeat (4) @(negedge clk_in);
         // an undriven dout reads as unknown so it can never match
         if (i >= 8) rd = {rd[14:0], (spi_dout_oe_in === 1'b1) ? spi_dout_in : 1'bx};
         spi_sclk_out <= 1'b0;
         repeat (8) @(negedge clk_in);
         spi_sclk_out <= 1'b1;
         repeat (4) @(negedge clk_in);
      end
      spi_csn_out <= 1'b1;
      spi_din_out <= ~spi_din_out;
      repeat (10) @(negedge clk_in);
   endtask
   // quiet time after a software reset, 18 us at 25 ns
   task automatic soft_wait;
      repeat (720) @(negedge clk_in);
   endtask
endmodule

// *** dv/mgmc_regs_tb_top.sv ***
/*
 * mgmc_regs_tb_top: self-checking bench with a reference model of the register bank.
 * Assumes the host model and the bound checker are compiled before this file.
 */
`timescale 1ns/100ps
module mgmc_regs_tb_top;
   import mgmc_pkg::*;
   localparam logic [7:0] REV = 8'hC3; // arbitrary revision value
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic raw = 1'b0;
   logic [15:0] rd;
   wire csn, sclk, din, dout, oe, fpo, hpf, lpf, fpoff, cur, volt, swp, slp, pd, srst;
   wire [11:0] ga, gb, gc;
   int err_total = 0;
   int num_checks = 0;
   int cks = 0;
   int mdl [64];
   always #12.5 clk_in = ~clk_in;
   always @(negedge clk_in) raw <= 1'($urandom);
   // soft reset pulses seen on the port, checked once after the soft reset write and its 18 us quiet time
   int n_srst = 0;
   always @(posedge clk_in) if (srst === 1'b1) n_srst++;
   mgmc_host_model u_host (.clk_in(clk_in), .spi_csn_out(csn), .spi_sclk_out(sclk),
      .spi_din_out(din), .spi_dout_in(dout), .spi_dout_oe_in(oe));
   mgmc_regs #(.DIE_REVISION(REV)) uut (.clk_in(clk_in), .rstn_in(rstn_in), .spi_csn_in(csn),
      .spi_sclk_in(sclk), .spi_din_in(din), .spi_dout_out(dout), .spi_dout_oe_out(oe),
      .freq_pulse_raw_in(raw), .freq_pulse_output_out(fpo), .phase_a_apparent_gain_out(ga),
      .phase_b_apparent_gain_out(gb), .phase_c_apparent_gain_out(gc),
      .highpass_bypass_out(hpf), .lowpass_bypass_out(lpf), .freq_pulse_off_out(fpoff),
      .current_adc_off_out(cur), .voltage_adc_off_out(volt), .channel_swap_out(swp),
      .sleep_out(slp), .power_down_out(pd), .soft_reset_out(srst));
   // ==========================================================
   // model and comparison tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic int nbits(input int a);
      return (a >= 'h38 && a <= 'h3A) ? 16 : 8;
   endfunction
   task automatic wr(input int a, input int d);
      u_host.xfer({2'b10, a[5:0]}, d[15:0], nbits(a), rd);
      if (a == 'h0A && d[6]) begin
         for (int g = 'h38; g <= 'h3A; g++) mdl[g] = 0;
         mdl['h0A] = 'h04;
      end else if (a == 'h0A) begin
         mdl[a] = d & 'hBF;
      end else if (nbits(a) == 16) begin
         mdl[a] = d & 'hFFF;
      end
   endtask
   task automatic rdc(input int a);
      int e;
      e = (a == 'h3E) ? cks : mdl[a];
      u_host.xfer({2'b00, a[5:0]}, 16'h0000, nbits(a), rd);
      chk(rd, e[15:0]);
      cks = $countones(e);
   endtask
   task automatic chk_out;
      logic [7:0] m;
      logic r;
      m = mdl['h0A][7:0];
      // pulse output is the source one cycle late, gated by mode bit 2
      @(posedge clk_in);
      r = raw;
      @(negedge clk_in);
      chk({15'h0000, fpo}, {15'h0000, r & ~m[2]});
      chk({4'h0, ga}, mdl['h38][15:0]);
      chk({4'h0, gb}, mdl['h39][15:0]);
      chk({4'h0, gc}, mdl['h3A][15:0]);
      chk({8'h00, hpf, lpf, fpoff, cur, volt, swp, slp, pd}, {8'h00, m[0], m[1], m[2],
         m[3] & ~m[4], m[4] & ~m[3], m[5] & ~(m[3] & m[4]), m[3] & m[4] & ~m[5], &m[5:3]});
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ==========================================================
   // tests
   initial begin
      void'($urandom(25059));
      mdl = '{default: 0};
      mdl['h0A] = 'h04;
      mdl['h3F] = REV;
      repeat (20) @(negedge clk_in);
      rstn_in = 1'b1;
      repeat (4) @(negedge clk_in);
      chk_out;
      foreach (mdl[a]) if (a == 'h0A || a >= 'h38) rdc(a);
      $display("test reset values done");
      wr('h38, 'hFFFF);
      rdc('h38);
      for (int a = 'h38; a <= 'h3A; a++) begin
         wr(a, $urandom_range(0, 'hFFFF));
         chk_out;
         rdc(a);
         rdc('h3E);
      end
      $display("test gains done");
      for (int f = 0; f < 8; f++) begin
         wr('h0A, ($urandom & 'h87) | (f << 3));
         chk_out;
         rdc('h0A);
      end
      $display("test mode codes done");
      for (int a = 'h3B; a <= 'h3F; a++) wr(a, $urandom);
      chk_out;
      for (int a = 'h38; a <= 'h3F; a++) rdc(a);
      $display("test refused writes done");
      wr('h39, 'h0ABC);
      wr('h0A, 'h41);
      u_host.soft_wait;
      chk(16'(n_srst), 16'h0001);
      chk_out;
      rdc('h39);
      rdc('h0A);
      wr('h0A, 'h00);
      chk_out;
      $display("test soft reset done");
      results;
   end
   initial begin
      repeat (60000) @(posedge clk_in);
      err_total++;
      results;
   end
endmodule
